// ===== tac_clock_select.sv
`timescale 1ns/1ns

module tac_clock_select (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// crystal pins
	input wire logic crystal_osc_in,
	output logic crystal_osc_out,
	// control
	input wire logic async_clock_select,
	input wire logic [2:0] clock_select_field,
	input wire logic enable,
	// timer clock enable
	output logic tick
);

	// ==========================================================
	// crystal synchroniser
	logic x_meta_q;
	logic x_sync_q;
	logic x_prev_q;
	logic x_rise;
	logic src_tick;
	logic [tac_pkg::PRESC_W-1:0] presc_q;

	// division by 2**(cs-1); stop code gives no tick at all
	function automatic logic [tac_pkg::PRESC_W-1:0] presc_mask(input logic [2:0] cs);
		logic [tac_pkg::PRESC_W:0] one_hot;
		one_hot = '0;
		if (cs != tac_pkg::CS_STOP) begin
			one_hot[cs - 3'h1] = 1'b1;
		end
		presc_mask = tac_pkg::PRESC_W'(one_hot - 1'b1);
	endfunction : presc_mask

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			x_meta_q <= 1'b0;
			x_sync_q <= 1'b0;
			x_prev_q <= 1'b0;
		end else begin
			x_meta_q <= crystal_osc_in;
			x_sync_q <= x_meta_q;
			x_prev_q <= x_sync_q;
		end
	end

	// oscillator feedback, kept registered so the pin never glitches
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crystal_osc_out <= 1'b1;
		end else begin
			crystal_osc_out <= ~x_sync_q;
		end
	end

	assign x_rise = x_sync_q & ~x_prev_q;
	assign src_tick = async_clock_select ? x_rise : 1'b1;

	// ==========================================================
	// prescaler
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			presc_q <= '0;
		end else if (src_tick && enable) begin
			presc_q <= presc_q + 1'b1;
		end
	end

	assign tick = enable && src_tick && (clock_select_field != tac_pkg::CS_STOP)
		&& ((presc_q & presc_mask(clock_select_field)) == presc_mask(clock_select_field));

endmodule : tac_clock_select

// ===== tac_pkg.sv
package tac_pkg;

	// ==========================================================
	// widths and limits
	localparam int CNT_W = 8;
	localparam int ADDR_W = 8;
	localparam int NUM_CH = 2;
	localparam int PRESC_W = 6;
	localparam logic [7:0] BOTTOM_VAL = 8'h00;
	localparam logic [7:0] MAX_VAL = 8'hFF;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_COUNTER = 8'h00;
	localparam logic [7:0] OFS_CMP_A = 8'h04;
	localparam logic [7:0] OFS_CMP_B = 8'h08;
	localparam logic [7:0] OFS_CTRL_A = 8'h0C;
	localparam logic [7:0] OFS_CTRL_B = 8'h10;
	localparam logic [7:0] OFS_FLAG = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;
	localparam logic [7:0] OFS_ASYNC = 8'h1C;
	localparam logic [7:0] OFS_POWER = 8'h20;

	// ==========================================================
	// field positions
	localparam int POS_COM_A = 6;
	localparam int POS_COM_B = 4;
	localparam int POS_WGM_LO = 0;
	localparam int POS_FORCE_A = 7;
	localparam int POS_FORCE_B = 6;
	localparam int POS_WGM_HI = 3;
	localparam int POS_CS = 0;
	localparam int POS_FLAG_OVF = 0;
	localparam int POS_FLAG_CMP_A = 1;
	localparam int POS_FLAG_CMP_B = 2;
	localparam int POS_ASYNC_SEL = 0;
	localparam int POS_POWER = 0;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_COUNTER = 8'h00;
	localparam logic [7:0] RST_CMP = 8'h00;
	localparam logic [2:0] RST_FLAGS = 3'h0;
	localparam logic [2:0] RST_MASK = 3'h0;
	localparam logic [2:0] CS_STOP = 3'h0;

	// ==========================================================
	// waveform modes
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_PHASE_MAX = 3'h1;
	localparam logic [2:0] WGM_CTC = 3'h2;
	localparam logic [2:0] WGM_FAST_MAX = 3'h3;
	localparam logic [2:0] WGM_PHASE_A = 3'h5;
	localparam logic [2:0] WGM_FAST_A = 3'h7;

	// compare output actions
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	typedef enum logic [1:0] {
		TAC_DIR_UP = 2'b01,
		TAC_DIR_DOWN = 2'b10
	} tac_dir_t;

	typedef struct packed {
		logic [1:0] com_a;
		logic [1:0] com_b;
		logic [2:0] wgm;
		logic [2:0] cs;
	} tac_ctrl_t;

	typedef struct packed {
		logic cmp_b;
		logic cmp_a;
		logic ovf;
	} tac_flags_t;

endpackage : tac_pkg

// ===== tac_timer_core.sv
`timescale 1ns/1ns

module tac_timer_core (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tac_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// crystal pins
	input wire logic crystal_osc_in,
	output logic crystal_osc_out,
	// compare outputs
	output logic compare_out_a,
	output logic compare_out_b,
	// masked requests
	output tac_pkg::tac_flags_t irq_req
);

	// ==========================================================
	// reset release
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ==========================================================
	// state
	localparam int NCH = tac_pkg::NUM_CH;
	logic [tac_pkg::CNT_W-1:0] counter_value_q;
	logic [tac_pkg::CNT_W-1:0] counter_value_d;
	logic [NCH-1:0][tac_pkg::CNT_W-1:0] cmp_buf_q;
	logic [NCH-1:0][tac_pkg::CNT_W-1:0] cmp_act_q;
	tac_pkg::tac_ctrl_t ctrl_q;
	tac_pkg::tac_flags_t flags_q;
	tac_pkg::tac_flags_t mask_q;
	tac_pkg::tac_dir_t dir_q;
	tac_pkg::tac_dir_t dir_d;
	logic async_clock_select_q;
	logic timer_power_reduce_bit_q;
	logic block_q;
	logic [NCH-1:0] oc_q;
	logic [31:0] prdata_q;
	logic err_q;

	// ==========================================================
	// mode decode
	function automatic logic mode_phase(input logic [2:0] wgm);
		mode_phase = (wgm == tac_pkg::WGM_PHASE_MAX) || (wgm == tac_pkg::WGM_PHASE_A);
	endfunction : mode_phase

	function automatic logic mode_fast(input logic [2:0] wgm);
		mode_fast = (wgm == tac_pkg::WGM_FAST_MAX) || (wgm == tac_pkg::WGM_FAST_A);
	endfunction : mode_fast

	function automatic logic mode_top_a(input logic [2:0] wgm);
		mode_top_a = (wgm == tac_pkg::WGM_CTC) || (wgm == tac_pkg::WGM_PHASE_A)
			|| (wgm == tac_pkg::WGM_FAST_A);
	endfunction : mode_top_a

	function automatic logic [1:0] com_of(input tac_pkg::tac_ctrl_t c, input int ch);
		com_of = (ch == 0) ? c.com_a : c.com_b;
	endfunction : com_of

	logic is_phase;
	logic is_fast;
	logic is_pwm;
	logic [tac_pkg::CNT_W-1:0] top_val;
	logic at_top;
	logic at_bottom;
	logic at_max;
	logic tick;

	assign is_phase = mode_phase(ctrl_q.wgm);
	assign is_fast = mode_fast(ctrl_q.wgm);
	assign is_pwm = is_phase | is_fast;
	assign top_val = mode_top_a(ctrl_q.wgm) ? cmp_act_q[0] : tac_pkg::MAX_VAL;
	assign at_top = (counter_value_q == top_val);
	assign at_bottom = (counter_value_q == tac_pkg::BOTTOM_VAL);
	assign at_max = (counter_value_q == tac_pkg::MAX_VAL);

	// ==========================================================
	// timer clock
	tac_clock_select u_clock_select (
		.clk_sys(clk_sys),
		.rst_n(rst_n_q),
		.crystal_osc_in(crystal_osc_in),
		.crystal_osc_out(crystal_osc_out),
		.async_clock_select(async_clock_select_q),
		.clock_select_field(ctrl_q.cs),
		.enable(~timer_power_reduce_bit_q),
		.tick(tick)
	);

	// ==========================================================
	// apb decode
	logic setup_ph;
	logic wr_acc;
	logic addr_ok;
	logic wr_cnt;

	function automatic logic addr_mapped(input logic [tac_pkg::ADDR_W-1:0] a);
		unique case (a)
			tac_pkg::OFS_COUNTER, tac_pkg::OFS_CMP_A, tac_pkg::OFS_CMP_B,
			tac_pkg::OFS_CTRL_A, tac_pkg::OFS_CTRL_B, tac_pkg::OFS_FLAG,
			tac_pkg::OFS_MASK, tac_pkg::OFS_ASYNC, tac_pkg::OFS_POWER: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction : addr_mapped

	assign setup_ph = psel & ~penable;
	assign addr_ok = addr_mapped(paddr);
	assign wr_acc = psel & penable & pwrite & addr_ok;
	assign wr_cnt = wr_acc && (paddr == tac_pkg::OFS_COUNTER);

	logic [7:0] wbyte;
	assign wbyte = pwdata[7:0];

	// ==========================================================
	// counter
	always_comb begin
		counter_value_d = counter_value_q;
		dir_d = dir_q;
		if (tick) begin
			if (is_phase) begin
				unique case (dir_q)
					tac_pkg::TAC_DIR_UP: begin
						if (at_top) begin
							dir_d = tac_pkg::TAC_DIR_DOWN;
						end
					end
					tac_pkg::TAC_DIR_DOWN: begin
						if (at_bottom) begin
							dir_d = tac_pkg::TAC_DIR_UP;
						end
					end
				endcase
				if (dir_d == tac_pkg::TAC_DIR_UP) begin
					counter_value_d = counter_value_q + 8'h01;
				end else begin
					counter_value_d = counter_value_q - 8'h01;
				end
			end else if (mode_top_a(ctrl_q.wgm) || is_fast) begin
				// ctc and fast pwm: clear at top, otherwise count up
				dir_d = tac_pkg::TAC_DIR_UP;
				if (at_top) begin
					counter_value_d = '0;
				end else begin
					counter_value_d = counter_value_q + 8'h01;
				end
			end else begin
				dir_d = tac_pkg::TAC_DIR_UP;
				counter_value_d = counter_value_q + 8'h01;
			end
		end
		if (wr_cnt) begin
			counter_value_d = wbyte;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			counter_value_q <= tac_pkg::RST_COUNTER;
			dir_q <= tac_pkg::TAC_DIR_UP;
		end else begin
			counter_value_q <= counter_value_d;
			dir_q <= dir_d;
		end
	end

	// a counter write masks the match of the next timer tick, even when stopped
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			block_q <= 1'b0;
		end else if (wr_cnt) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	// ==========================================================
	// compare channels
	logic [NCH-1:0] match;
	logic [NCH-1:0] cmp_evt;
	logic [NCH-1:0] force_strobe;
	logic [NCH-1:0] wr_cmp;
	logic reload;

	assign force_strobe[0] = wr_acc && (paddr == tac_pkg::OFS_CTRL_B)
		&& pwdata[tac_pkg::POS_FORCE_A];
	assign force_strobe[1] = wr_acc && (paddr == tac_pkg::OFS_CTRL_B)
		&& pwdata[tac_pkg::POS_FORCE_B];
	assign wr_cmp[0] = wr_acc && (paddr == tac_pkg::OFS_CMP_A);
	assign wr_cmp[1] = wr_acc && (paddr == tac_pkg::OFS_CMP_B);
	// pwm reloads at top so a pulse is never cut short
	assign reload = tick && at_top;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			logic [1:0] com_sel;
			assign com_sel = com_of(ctrl_q, ch);
			assign match[ch] = (counter_value_q == cmp_act_q[ch]);
			assign cmp_evt[ch] = tick && match[ch] && !block_q;

			always_ff @(posedge clk_sys or negedge rst_n_q) begin
				if (!rst_n_q) begin
					cmp_buf_q[ch] <= tac_pkg::RST_CMP;
				end else if (wr_cmp[ch]) begin
					cmp_buf_q[ch] <= wbyte;
				end
			end

			always_ff @(posedge clk_sys or negedge rst_n_q) begin
				if (!rst_n_q) begin
					cmp_act_q[ch] <= tac_pkg::RST_CMP;
				end else if (!is_pwm) begin
					cmp_act_q[ch] <= wr_cmp[ch] ? wbyte : cmp_buf_q[ch];
				end else if (reload) begin
					cmp_act_q[ch] <= cmp_buf_q[ch];
				end
			end

			// waveform state per channel
			always_ff @(posedge clk_sys or negedge rst_n_q) begin
				if (!rst_n_q) begin
					oc_q[ch] <= 1'b0;
				end else if (!is_pwm) begin
					if (cmp_evt[ch] || force_strobe[ch]) begin
						unique case (com_sel)
							tac_pkg::COM_OFF: oc_q[ch] <= oc_q[ch];
							tac_pkg::COM_TOGGLE: oc_q[ch] <= ~oc_q[ch];
							tac_pkg::COM_CLEAR: oc_q[ch] <= 1'b0;
							tac_pkg::COM_SET: oc_q[ch] <= 1'b1;
						endcase
					end
				end else if (com_sel[1]) begin
					if (is_fast && reload) begin
						oc_q[ch] <= ~com_sel[0];
					end else if (cmp_evt[ch]) begin
						if (is_fast || dir_q == tac_pkg::TAC_DIR_UP) begin
							oc_q[ch] <= com_sel[0];
						end else begin
							oc_q[ch] <= ~com_sel[0];
						end
					end
				end
			end
		end
	endgenerate

	assign compare_out_a = oc_q[0];
	assign compare_out_b = oc_q[1];

	// ==========================================================
	// flags
	tac_pkg::tac_flags_t set_evt;
	tac_pkg::tac_flags_t clr_req;
	logic ovf_point;

	// overflow point: bottom turn-around in phase pwm, top in fast pwm, else max
	assign ovf_point = is_phase ? (dir_q == tac_pkg::TAC_DIR_DOWN && at_bottom)
		: (is_fast ? at_top : at_max);
	assign set_evt.ovf = tick && ovf_point && !wr_cnt;
	assign set_evt.cmp_a = cmp_evt[0];
	assign set_evt.cmp_b = cmp_evt[1];
	assign clr_req.ovf = wr_acc && (paddr == tac_pkg::OFS_FLAG) && pwdata[tac_pkg::POS_FLAG_OVF];
	assign clr_req.cmp_a = wr_acc && (paddr == tac_pkg::OFS_FLAG)
		&& pwdata[tac_pkg::POS_FLAG_CMP_A];
	assign clr_req.cmp_b = wr_acc && (paddr == tac_pkg::OFS_FLAG)
		&& pwdata[tac_pkg::POS_FLAG_CMP_B];

	// a set arriving with a clear wins, so no event is lost
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flags_q <= tac_pkg::RST_FLAGS;
		end else begin
			flags_q <= (flags_q & ~clr_req) | set_evt;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mask_q <= tac_pkg::RST_MASK;
		end else if (wr_acc && paddr == tac_pkg::OFS_MASK) begin
			mask_q <= pwdata[2:0];
		end
	end

	assign irq_req = flags_q & mask_q;

	// ==========================================================
	// control registers
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= '0;
		end else if (wr_acc && paddr == tac_pkg::OFS_CTRL_A) begin
			ctrl_q.com_a <= pwdata[tac_pkg::POS_COM_A +: 2];
			ctrl_q.com_b <= pwdata[tac_pkg::POS_COM_B +: 2];
			ctrl_q.wgm[1:0] <= pwdata[tac_pkg::POS_WGM_LO +: 2];
		end else if (wr_acc && paddr == tac_pkg::OFS_CTRL_B) begin
			ctrl_q.wgm[2] <= pwdata[tac_pkg::POS_WGM_HI];
			ctrl_q.cs <= pwdata[tac_pkg::POS_CS +: 3];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			async_clock_select_q <= 1'b0;
		end else if (wr_acc && paddr == tac_pkg::OFS_ASYNC) begin
			async_clock_select_q <= pwdata[tac_pkg::POS_ASYNC_SEL];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			timer_power_reduce_bit_q <= 1'b0;
		end else if (wr_acc && paddr == tac_pkg::OFS_POWER) begin
			timer_power_reduce_bit_q <= pwdata[tac_pkg::POS_POWER];
		end
	end

	// ==========================================================
	// read path, sampled in the setup cycle so data stand from a flop
	logic [7:0] rd_byte;

	always_comb begin
		rd_byte = 8'h00;
		unique case (paddr)
			tac_pkg::OFS_COUNTER: rd_byte = counter_value_q;
			tac_pkg::OFS_CMP_A: rd_byte = cmp_buf_q[0];
			tac_pkg::OFS_CMP_B: rd_byte = cmp_buf_q[1];
			tac_pkg::OFS_CTRL_A: rd_byte = {ctrl_q.com_a, ctrl_q.com_b, 2'h0, ctrl_q.wgm[1:0]};
			tac_pkg::OFS_CTRL_B: rd_byte = {4'h0, ctrl_q.wgm[2], ctrl_q.cs};
			tac_pkg::OFS_FLAG: rd_byte = {5'h00, flags_q};
			tac_pkg::OFS_MASK: rd_byte = {5'h00, mask_q};
			tac_pkg::OFS_ASYNC: rd_byte = {7'h00, async_clock_select_q};
			tac_pkg::OFS_POWER: rd_byte = {7'h00, timer_power_reduce_bit_q};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else if (setup_ph) begin
			prdata_q <= {24'h00_0000, rd_byte};
			err_q <= ~addr_ok;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & err_q;

endmodule : tac_timer_core

// ===== tac_timer_core_sva.sv
`timescale 1ns/1ns
module tac_timer_core_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic crystal_osc_in,
	input wire logic crystal_osc_out,
	input wire logic compare_out_a,
	input wire logic compare_out_b,
	input wire tac_pkg::tac_flags_t irq_req
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic acc;
	assign acc = psel && penable;
	// ==========================================================
	// bus
	ready_high_a: assert property (pready) else $error("pready low");
	err_phase_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
	mapped_ok_a: assert property (acc && paddr <= tac_pkg::OFS_POWER && paddr[1:0] == 2'h0
		|-> !pslverr) else $error("pslverr on mapped address");
	upper_zero_a: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
	unmapped_zero_a: assert property (acc && !pwrite && paddr > tac_pkg::OFS_POWER
		|-> prdata == 32'h0) else $error("unmapped read not zero");
	strobe_zero_a: assert property (acc && !pwrite && paddr == tac_pkg::OFS_CTRL_B
		|-> prdata[7:6] == 2'h0) else $error("force strobes read back");
	// ==========================================================
	// requests and pins
	mask_gate_a: assert property (acc && pwrite && paddr == tac_pkg::OFS_MASK && pwdata[2:0] == 3'h0
		|-> ##2 irq_req == 3'h0) else $error("request not masked");
	osc_high_a: assert property (crystal_osc_in [*8] |-> !crystal_osc_out)
		else $error("crystal out not inverted");
	osc_low_a: assert property (!crystal_osc_in [*8] |-> crystal_osc_out)
		else $error("crystal out not inverted");
	cover property (acc && pslverr);
	cover property ($rose(compare_out_a));
	cover property ($rose(compare_out_b));
	cover property ($rose(irq_req.ovf));
endmodule : tac_timer_core_sva

bind tac_timer_core tac_timer_core_sva chk (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .crystal_osc_in, .crystal_osc_out, .compare_out_a,
	.compare_out_b, .irq_req);

// ===== tac_timer_core_test.sv
`timescale 1ns/1ns
module tac_timer_core_test;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic crystal_osc_in = 1'b0;
	logic crystal_osc_out;
	logic compare_out_a;
	logic compare_out_b;
	tac_pkg::tac_flags_t irq_req;
	int n_errors = 0;
	int n_checks = 0;
	int seed = 74;
	logic [2:0] modes [6] = '{tac_pkg::WGM_NORMAL, tac_pkg::WGM_PHASE_MAX, tac_pkg::WGM_CTC,
		tac_pkg::WGM_FAST_MAX, tac_pkg::WGM_PHASE_A, tac_pkg::WGM_FAST_A};

	always #5 clk_sys = ~clk_sys;

	tac_timer_core uut (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .crystal_osc_in, .crystal_osc_out, .compare_out_a, .compare_out_b,
		.irq_req);

	// ==========================================================
	// reporting
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up

	task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_val

	task automatic check_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t %s got %b", $time, what, got);
		end
	endtask : check_bit

	// ==========================================================
	// apb master
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_errors++;
			$display("ERROR %0t bus timeout", $time);
			wrap_up();
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		v = r[7:0];
	endtask : rd

	function automatic logic [7:0] ctla(logic [1:0] ca, logic [1:0] cb, logic [2:0] m);
		return (8'(ca) << tac_pkg::POS_COM_A) | (8'(cb) << tac_pkg::POS_COM_B) | 8'(m[1:0]);
	endfunction : ctla

	function automatic logic [7:0] ctlb(logic [2:0] m, logic [2:0] cs, logic fa, logic fb);
		return (8'(m[2]) << tac_pkg::POS_WGM_HI) | 8'(cs) | (8'(fa) << tac_pkg::POS_FORCE_A)
			| (8'(fb) << tac_pkg::POS_FORCE_B);
	endfunction : ctlb

	task automatic set_mode(input logic [2:0] m, input logic [2:0] cs);
		wr(tac_pkg::OFS_CTRL_A, ctla(tac_pkg::COM_OFF, tac_pkg::COM_OFF, m));
		wr(tac_pkg::OFS_CTRL_B, ctlb(m, cs, 1'b0, 1'b0));
	endtask : set_mode

	// ==========================================================
	// main sequence
	initial begin
		logic [7:0] v;
		logic [7:0] w;
		logic [7:0] c;
		logic [31:0] r;
		logic e;
		int k;
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (k = 0; k < 9; k++) begin
			rd(8'(4 * k), v);
			check_val(v, 8'h00, "reset value");
		end
		// unmapped places refuse both directions
		c = 8'h80 | (8'($random(seed)) & 8'h7C);
		apb(1'b1, c, 32'hFF, r, e);
		check_bit(e, 1'b1, "write slverr");
		apb(1'b0, c, 32'h0, r, e);
		check_bit(e, 1'b1, "read slverr");
		v = 8'($random(seed));
		wr(tac_pkg::OFS_COUNTER, v);
		repeat (20) @(posedge clk_sys);
		rd(tac_pkg::OFS_COUNTER, w);
		check_val(w, v, "stopped hold");
		for (k = 0; k < 6; k++) begin
			set_mode(modes[k], tac_pkg::CS_STOP);
			rd(tac_pkg::OFS_CTRL_A, w);
			check_val(w, ctla(tac_pkg::COM_OFF, tac_pkg::COM_OFF, modes[k]), "ctrl a");
			rd(tac_pkg::OFS_CTRL_B, w);
			check_val(w, ctlb(modes[k], tac_pkg::CS_STOP, 1'b0, 1'b0), "ctrl b");
		end
		// reads are three clocks apart, one tick per clock
		set_mode(tac_pkg::WGM_NORMAL, 3'h1);
		rd(tac_pkg::OFS_COUNTER, v);
		rd(tac_pkg::OFS_COUNTER, w);
		check_val(w - v, 8'h03, "step");
		wr(tac_pkg::OFS_COUNTER, 8'h40);
		rd(tac_pkg::OFS_COUNTER, w);
		check_val(w, 8'h41, "running write");
		// wrap to zero sets overflow and both matches against zero compares
		wr(tac_pkg::OFS_MASK, 8'h07);
		wr(tac_pkg::OFS_COUNTER, tac_pkg::MAX_VAL - 8'h0F);
		wr(tac_pkg::OFS_FLAG, 8'h07);
		repeat (40) @(posedge clk_sys);
		rd(tac_pkg::OFS_FLAG, v);
		check_val(v, 8'h07, "wrap flags");
		check_val(8'(irq_req), 8'h07, "requests");
		wr(tac_pkg::OFS_MASK, 8'h00);
		repeat (2) @(posedge clk_sys);
		check_val(8'(irq_req), 8'h00, "masked");
		wr(tac_pkg::OFS_FLAG, 8'h07);
		rd(tac_pkg::OFS_FLAG, v);
		check_val(v, 8'h00, "flag clear");
		// a counter write hides the match at the first tick
		set_mode(tac_pkg::WGM_NORMAL, tac_pkg::CS_STOP);
		c = 8'($random(seed)) & 8'h7F;
		wr(tac_pkg::OFS_CMP_A, c);
		wr(tac_pkg::OFS_CMP_B, c + 8'h80);
		wr(tac_pkg::OFS_COUNTER, c);
		wr(tac_pkg::OFS_FLAG, 8'h07);
		set_mode(tac_pkg::WGM_NORMAL, 3'h1);
		repeat (10) @(posedge clk_sys);
		rd(tac_pkg::OFS_FLAG, v);
		check_val(v, 8'h00, "blocked match");
		// clear on compare a keeps the count at or below it
		set_mode(tac_pkg::WGM_NORMAL, tac_pkg::CS_STOP);
		c = 8'h10 + (8'($random(seed)) & 8'h1F);
		wr(tac_pkg::OFS_CMP_A, c);
		wr(tac_pkg::OFS_CMP_B, c >> 1);
		wr(tac_pkg::OFS_COUNTER, tac_pkg::BOTTOM_VAL);
		wr(tac_pkg::OFS_FLAG, 8'h07);
		set_mode(tac_pkg::WGM_CTC, 3'h1);
		for (k = 0; k < 8; k++) begin
			repeat ($random(seed) & 7) @(posedge clk_sys);
			rd(tac_pkg::OFS_COUNTER, w);
			check_bit(w <= c, 1'b1, "ctc top");
		end
		// the random waits may be short, so let the count reach compare a for sure
		repeat (100) @(posedge clk_sys);
		rd(tac_pkg::OFS_FLAG, v);
		check_val(v, 8'h06, "compare flags");
		// forced compares move the pins but set no flag
		set_mode(tac_pkg::WGM_NORMAL, tac_pkg::CS_STOP);
		wr(tac_pkg::OFS_FLAG, 8'h07);
		wr(tac_pkg::OFS_CTRL_A, ctla(tac_pkg::COM_TOGGLE, tac_pkg::COM_SET, tac_pkg::WGM_NORMAL));
		e = compare_out_a;
		wr(tac_pkg::OFS_CTRL_B, ctlb(tac_pkg::WGM_NORMAL, tac_pkg::CS_STOP, 1'b1, 1'b1));
		repeat (2) @(posedge clk_sys);
		check_bit(compare_out_a, ~e, "toggle a");
		check_bit(compare_out_b, 1'b1, "set b");
		rd(tac_pkg::OFS_FLAG, v);
		check_val(v, 8'h00, "force flags");
		// crystal edges are the only ticks
		wr(tac_pkg::OFS_ASYNC, 8'h01);
		wr(tac_pkg::OFS_COUNTER, tac_pkg::BOTTOM_VAL);
		set_mode(tac_pkg::WGM_NORMAL, 3'h1);
		for (k = 0; k < 5; k++) begin
			repeat (10) @(posedge clk_sys);
			crystal_osc_in <= 1'b1;
			repeat (10) @(posedge clk_sys);
			crystal_osc_in <= 1'b0;
		end
		repeat (10) @(posedge clk_sys);
		check_bit(crystal_osc_out, 1'b1, "crystal out");
		rd(tac_pkg::OFS_COUNTER, w);
		check_val(w, 8'h05, "crystal count");
		wr(tac_pkg::OFS_ASYNC, 8'h00);
		// power reduce stops the ticks
		wr(tac_pkg::OFS_POWER, 8'h01);
		wr(tac_pkg::OFS_COUNTER, v);
		repeat (20) @(posedge clk_sys);
		rd(tac_pkg::OFS_COUNTER, w);
		check_val(w, v, "power hold");
		wr(tac_pkg::OFS_POWER, 8'h00);
		// phase pwm with top from compare a turns round and overflows at the bottom
		set_mode(tac_pkg::WGM_NORMAL, tac_pkg::CS_STOP);
		wr(tac_pkg::OFS_CMP_A, 8'h20);
		wr(tac_pkg::OFS_COUNTER, tac_pkg::BOTTOM_VAL);
		wr(tac_pkg::OFS_FLAG, 8'h07);
		set_mode(tac_pkg::WGM_PHASE_A, 3'h1);
		for (k = 0; k < 8; k++) begin
			repeat (($random(seed) & 15) + 4) @(posedge clk_sys);
			rd(tac_pkg::OFS_COUNTER, w);
			check_bit(w <= 8'h20, 1'b1, "phase top");
		end
		repeat (80) @(posedge clk_sys);
		rd(tac_pkg::OFS_FLAG, v);
		check_val(v, 8'h07, "phase flags");
		wrap_up();
	end
endmodule : tac_timer_core_test
